// *** rtl/apc_page_regs.sv ***
`timescale 1ns/1ps
`include "apc_consts.svh"

module apc_page_regs
    import apc_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = 7'h4c  // arbitrary bus address
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic       activity_detect_enable_i,
    input  wire logic       recording_active_i,
    input  wire logic       detector_event_i,
    input  wire logic       asi_data_i,
    output logic [1:0]      auto_power_policy_o,
    output logic            event_power_up_en_o,
    output logic            event_power_down_en_o,
    output logic [1:0]      monitored_channel_select_o,
    output logic [1:0]      detector_clock_source_o,
    output logic            use_custom_clock_o,
    output logic [1:0]      external_clock_rate_select_o,
    output logic            serial_out_interrupt_mode_o,
    output logic            detector_run_o,
    output logic            serial_data_output_pin_o,
    output logic [7:0]      current_page_o
);

    // ======================================================================
    // storage
    logic [7:0] page_r;
    logic [7:0] cfg_one_r;
    logic [7:0] cfg_two_r;
    logic [7:0] cksum_r;

    // ======================================================================
    // pin synchronisers and edge history
    logic       scl_s1_r;
    logic       scl_s2_r;
    logic       scl_d_r;
    logic       sda_s1_r;
    logic       sda_s2_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    // the first stage is read only by the second, to keep metastability out
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r  <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r  <= 1'b1;
        end else begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r  <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r  <= sda_s2_r;
        end
    end

    // start and stop are data edges while the clock stays high
    assign scl_rise  = scl_s2_r & ~scl_d_r;
    assign scl_fall  = ~scl_s2_r & scl_d_r;
    assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
    assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

    // ======================================================================
    // serial control port
    apc_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic [7:0] ptr_r;
    logic       rw_r;
    logic       sda_oe_n_r;
    logic       wr_stb;
    logic [7:0] rd_data;

    // a byte is complete on the falling edge after its eighth rising edge
    assign wr_stb = scl_fall && (state_r == APC_WDATA) &&
                    (bit_cnt_r == `APC_BITS_PER_BYTE);

    // read mux; unmapped locations answer zero
    always_comb begin
        rd_data = 8'h00;
        if (ptr_r == `APC_OFS_PAGE) begin
            rd_data = page_r;
        end else if (page_r == `APC_PAGE_ONE) begin
            if (ptr_r == `APC_OFS_CFG_ONE) begin
                rd_data = cfg_one_r;
            end else if (ptr_r == `APC_OFS_CFG_TWO) begin
                rd_data = cfg_two_r & `APC_CFG_TWO_WR_MASK;
            end
        end else if (page_r == `APC_PAGE_ZERO &&
                     ptr_r == `APC_OFS_CKSUM) begin
            rd_data = cksum_r;
        end
    end

    // sampling on the rising clock edge, driving on the falling one
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_r    <= APC_IDLE;
            bit_cnt_r  <= 4'h0;
            shift_r    <= 8'h00;
            tx_r       <= 8'h00;
            ptr_r      <= 8'h00;
            rw_r       <= 1'b0;
            sda_oe_n_r <= 1'b1;
        end else if (bus_stop) begin
            state_r    <= APC_IDLE;
            sda_oe_n_r <= 1'b1;
        end else if (bus_start) begin
            state_r    <= APC_ADDR;
            bit_cnt_r  <= 4'h0;
            sda_oe_n_r <= 1'b1;
        end else if (scl_rise) begin
            case (state_r)
                APC_ADDR, APC_REG, APC_WDATA: begin
                    shift_r   <= {shift_r[6:0], sda_s2_r};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                APC_RDATA: begin
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                APC_ACK_R: begin
                    // a not-acknowledge ends the read burst
                    if (sda_s2_r) begin
                        state_r <= APC_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state_r)
                APC_ADDR: begin
                    if (bit_cnt_r == `APC_BITS_PER_BYTE) begin
                        if (shift_r[7:1] == DEV_ADDR) begin
                            rw_r       <= shift_r[0];
                            sda_oe_n_r <= 1'b0;
                            state_r    <= APC_ACK_ADDR;
                        end else begin
                            state_r    <= APC_IDLE;
                        end
                    end
                end
                APC_ACK_ADDR: begin
                    bit_cnt_r <= 4'h0;
                    if (rw_r) begin
                        tx_r       <= rd_data;
                        sda_oe_n_r <= rd_data[7];
                        state_r    <= APC_RDATA;
                    end else begin
                        sda_oe_n_r <= 1'b1;
                        state_r    <= APC_REG;
                    end
                end
                APC_REG: begin
                    if (bit_cnt_r == `APC_BITS_PER_BYTE) begin
                        ptr_r      <= shift_r;
                        sda_oe_n_r <= 1'b0;
                        state_r    <= APC_ACK_REG;
                    end
                end
                APC_ACK_REG, APC_ACK_W: begin
                    bit_cnt_r  <= 4'h0;
                    sda_oe_n_r <= 1'b1;
                    state_r    <= APC_WDATA;
                end
                APC_WDATA: begin
                    if (bit_cnt_r == `APC_BITS_PER_BYTE) begin
                        ptr_r      <= ptr_r + 8'h01;
                        sda_oe_n_r <= 1'b0;
                        state_r    <= APC_ACK_W;
                    end
                end
                APC_RDATA: begin
                    if (bit_cnt_r == `APC_BITS_PER_BYTE) begin
                        ptr_r      <= ptr_r + 8'h01;
                        sda_oe_n_r <= 1'b1;
                        state_r    <= APC_ACK_R;
                    end else begin
                        sda_oe_n_r <= tx_r[3'h7 - bit_cnt_r[2:0]];
                    end
                end
                APC_ACK_R: begin
                    // acknowledged: next byte from the advanced pointer
                    bit_cnt_r  <= 4'h0;
                    tx_r       <= rd_data;
                    sda_oe_n_r <= rd_data[7];
                    state_r    <= APC_RDATA;
                end
                default: begin
                    sda_oe_n_r <= 1'b1;
                end
            endcase
        end
    end

    // ======================================================================
    // register writes
    // page select lives at offset zero whatever page is current
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            page_r <= `APC_RST_PAGE;
        end else if (wr_stb && ptr_r == `APC_OFS_PAGE) begin
            page_r <= shift_r;
        end
    end

    // other page-1 offsets are not stored; writes there are dropped
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_one_r <= `APC_RST_CFG_ONE;
        end else if (wr_stb && page_r == `APC_PAGE_ONE &&
                     ptr_r == `APC_OFS_CFG_ONE) begin
            cfg_one_r <= shift_r;
        end
    end

    // read-only bits are masked at write so they never leave zero
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cfg_two_r <= `APC_RST_CFG_TWO;
        end else if (wr_stb && page_r == `APC_PAGE_ONE &&
                     ptr_r == `APC_OFS_CFG_TWO) begin
            cfg_two_r <= shift_r & `APC_CFG_TWO_WR_MASK;
        end
    end

    // running byte sum; cheap, but only catches errors that do not cancel
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cksum_r <= `APC_RST_CKSUM;
        end else if (wr_stb) begin
            if (page_r == `APC_PAGE_ZERO && ptr_r == `APC_OFS_CKSUM) begin
                cksum_r <= shift_r;
            end else begin
                cksum_r <= cksum_r + shift_r;
            end
        end
    end

    // ======================================================================
    // decoded controls toward the detector and converters
    apc_policy_t policy;
    apc_clksrc_t clock_source_config;
    logic        int_mode;
    assign policy   = apc_policy_t'(cfg_one_r[`APC_POLICY_HI:`APC_POLICY_LO]);
    assign clock_source_config  = apc_clksrc_t'(cfg_one_r[`APC_CLKSRC_HI:`APC_CLKSRC_LO]);
    assign int_mode = cfg_two_r[`APC_SERIAL_DATA_OUTPUT_PIN_INT_BIT] & ~recording_active_i;

    // all controls are registered so outputs leave straight from flops
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            auto_power_policy_o          <= 2'h0;
            event_power_up_en_o          <= 1'b0;
            event_power_down_en_o        <= 1'b0;
            monitored_channel_select_o   <= 2'h2;
            detector_clock_source_o      <= 2'h0;
            use_custom_clock_o           <= 1'b0;
            external_clock_rate_select_o <= 2'h0;
        end else begin
            auto_power_policy_o   <= policy;
            event_power_up_en_o   <= (policy == APC_POL_EVENT) ||
                                     (policy == APC_POL_EVENT_UP);
            event_power_down_en_o <= (policy == APC_POL_EVENT) ||
                                     (policy == APC_POL_EVENT_DOWN);
            monitored_channel_select_o <=
                cfg_one_r[`APC_CHAN_HI:`APC_CHAN_LO];
            detector_clock_source_o <= clock_source_config;
            use_custom_clock_o <= (clock_source_config == APC_CLK_CUSTOM);
            external_clock_rate_select_o <=
                cfg_one_r[`APC_RATE_HI:`APC_RATE_LO];
        end
    end

    // detection gating and the shared serial data pin
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            detector_run_o              <= 1'b0;
            serial_out_interrupt_mode_o <= 1'b0;
            serial_data_output_pin_o    <= 1'b0;
        end else begin
            detector_run_o <= activity_detect_enable_i &&
                              (!recording_active_i ||
                               cfg_two_r[`APC_DET_REC_BIT]);
            serial_out_interrupt_mode_o <= int_mode;
            serial_data_output_pin_o <= int_mode ? detector_event_i
                                                 : asi_data_i;
        end
    end

    // ======================================================================
    // bus pin and page outputs
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sda_o          <= 1'b0;
            current_page_o <= `APC_RST_PAGE;
        end else begin
            sda_o          <= 1'b0;    // open drain: only ever pulls low
            current_page_o <= page_r;
        end
    end

    assign sda_oe_n_o = sda_oe_n_r;

endmodule // apc_page_regs

// *** rtl/apc_consts.svh ***
`ifndef APC_CONSTS_SVH
`define APC_CONSTS_SVH

// ==========================================================================
// register offsets and pages
`define APC_OFS_PAGE          8'h00
`define APC_OFS_CFG_ONE       8'h1e
`define APC_OFS_CFG_TWO       8'h1f
`define APC_OFS_CKSUM         8'h7e
`define APC_PAGE_ZERO         8'h00
`define APC_PAGE_ONE          8'h01

// ==========================================================================
// reset values
`define APC_RST_PAGE          8'h00
`define APC_RST_CFG_ONE       8'h20
`define APC_RST_CFG_TWO       8'h08
`define APC_RST_CKSUM         8'h00

// ==========================================================================
// field positions and masks
`define APC_POLICY_HI         7
`define APC_POLICY_LO         6
`define APC_CHAN_HI           5
`define APC_CHAN_LO           4
`define APC_CLKSRC_HI         3
`define APC_CLKSRC_LO         2
`define APC_RATE_HI           1
`define APC_RATE_LO           0
`define APC_SERIAL_DATA_OUTPUT_PIN_INT_BIT     6
`define APC_DET_REC_BIT       3
`define APC_CFG_TWO_WR_MASK   8'hd8

// ==========================================================================
// serial frame counts
`define APC_BITS_PER_BYTE     4'h8

`endif

// *** rtl/apc_pkg.sv ***
package apc_pkg;

    // ======================================================================
    // serial control port states
    typedef enum logic [3:0] {
        APC_IDLE     = 4'b0000,
        APC_ADDR     = 4'b0001,
        APC_ACK_ADDR = 4'b0010,
        APC_REG      = 4'b0011,
        APC_ACK_REG  = 4'b0100,
        APC_WDATA    = 4'b0101,
        APC_ACK_W    = 4'b0110,
        APC_RDATA    = 4'b0111,
        APC_ACK_R    = 4'b1000
    } apc_state_t;

    // ======================================================================
    // converter power policy codes
    typedef enum logic [1:0] {
        APC_POL_USER       = 2'b00,
        APC_POL_EVENT      = 2'b01,
        APC_POL_EVENT_UP   = 2'b10,
        APC_POL_EVENT_DOWN = 2'b11
    } apc_policy_t;

    // ======================================================================
    // detector clock source codes
    typedef enum logic [1:0] {
        APC_CLK_OSC    = 2'b00,
        APC_CLK_BIT    = 2'b01,
        APC_CLK_MASTER = 2'b10,
        APC_CLK_CUSTOM = 2'b11
    } apc_clksrc_t;

endpackage

// *** rtl/apc_pkg_dummy_guard.sv ***
`timescale 1ns/1ps

// *** testbench/apc_checker.sv ***
`timescale 1ns/1ps
// ======================================================================
// port level checks on the control port slice
module apc_checker (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       sda_oe_n_o,
    input wire logic       activity_detect_enable_i,
    input wire logic       recording_active_i,
    input wire logic       detector_event_i,
    input wire logic       asi_data_i,
    input wire logic [1:0] auto_power_policy_o,
    input wire logic       event_power_up_en_o,
    input wire logic       event_power_down_en_o,
    input wire logic [1:0] monitored_channel_select_o,
    input wire logic [1:0] detector_clock_source_o,
    input wire logic       use_custom_clock_o,
    input wire logic       serial_out_interrupt_mode_o,
    input wire logic       detector_run_o,
    input wire logic       serial_data_output_pin_o,
    input wire logic [7:0] current_page_o
);
    // one clock domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    reset_values_a: assert property (
        $rose(rst_n_i) |-> monitored_channel_select_o == 2'h2 &&
        current_page_o == 8'h00 && sda_oe_n_o)
        else $error("reset values wrong");
    policy_up_a: assert property (
        event_power_up_en_o == (auto_power_policy_o inside {2'h1, 2'h2}))
        else $error("power up enable wrong");
    policy_down_a: assert property (
        event_power_down_en_o == (auto_power_policy_o inside {2'h1, 2'h3}))
        else $error("power down enable wrong");
    custom_clock_a: assert property (
        use_custom_clock_o == (detector_clock_source_o == 2'h3))
        else $error("custom clock flag wrong");
    run_off_a: assert property (
        !$past(activity_detect_enable_i) |-> !detector_run_o)
        else $error("detector runs while disabled");
    run_idle_a: assert property (
        $past(rst_n_i) && $past(activity_detect_enable_i) &&
        !$past(recording_active_i) |-> detector_run_o)
        else $error("detector stopped while idle");
    int_recording_a: assert property (
        $past(recording_active_i) |-> !serial_out_interrupt_mode_o)
        else $error("interrupt mode while recording");
    pin_event_a: assert property (
        $past(rst_n_i) && $past(serial_out_interrupt_mode_o) &&
        serial_out_interrupt_mode_o |->
        serial_data_output_pin_o == $past(detector_event_i))
        else $error("pin does not follow detector event");
    pin_audio_a: assert property (
        $past(rst_n_i) && !$past(serial_out_interrupt_mode_o) &&
        !serial_out_interrupt_mode_o |->
        serial_data_output_pin_o == $past(asi_data_i))
        else $error("pin does not follow audio data");
endmodule // apc_checker

bind apc_page_regs apc_checker apc_checker_i (.clk_i, .rst_n_i,
    .sda_oe_n_o, .activity_detect_enable_i, .recording_active_i,
    .detector_event_i, .asi_data_i, .auto_power_policy_o,
    .event_power_up_en_o, .event_power_down_en_o,
    .monitored_channel_select_o, .detector_clock_source_o,
    .use_custom_clock_o, .serial_out_interrupt_mode_o, .detector_run_o,
    .serial_data_output_pin_o, .current_page_o);

// *** testbench/apc_host.sv ***
`timescale 1ns/1ps
// ======================================================================
// two wire host model; pins released means high through the pull-up
module apc_host #(
    parameter logic [6:0] ADDR = 7'h4c
) (
    input  wire logic       clk_i,
    input  wire logic       sda_i,
    output logic            scl_o,
    output logic            sda_o,
    output logic            rd_valid_o,
    output logic [7:0]      rd_data_o
);
    logic [7:0] rx;
    logic       a;

    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        rd_valid_o = 1'b0;
        rd_data_o = 8'h00;
    end

    // five clocks a phase keeps every level above the four clock floor
    task automatic q;
        repeat (5) @(posedge clk_i);
    endtask

    // data set while clock low, sampled just before the falling edge
    task automatic bitx(input logic b, output logic r);
        sda_o <= b;
        q;
        scl_o <= 1'b1;
        q;
        q;
        r = sda_i;
        scl_o <= 1'b0;
        q;
    endtask

    task automatic start;
        sda_o <= 1'b1;
        q;
        scl_o <= 1'b1;
        q;
        sda_o <= 1'b0;
        q;
        scl_o <= 1'b0;
        q;
    endtask

    task automatic stop;
        sda_o <= 1'b0;
        q;
        scl_o <= 1'b1;
        q;
        sda_o <= 1'b1;
        q;
    endtask

    // byte msb first, then the ninth bit; ok is the device acknowledge
    task automatic xb(input logic [7:0] tx, input logic ak,
                      output logic ok);
        for (int i = 7; i >= 0; i--)
            bitx(tx[i], rx[i]);
        bitx(ak, a);
        ok = !a;
    endtask

    task automatic wr(input logic [7:0] ra, input logic [7:0] d,
                      output logic ok);
        logic k1, k2, k3;
        start;
        xb({ADDR, 1'b0}, 1'b1, k1);
        xb(ra, 1'b1, k2);
        xb(d, 1'b1, k3);
        stop;
        ok = k1 & k2 & k3;
    endtask

    // single byte read, closed by a not-acknowledge from the host
    task automatic rd(input logic [7:0] ra, output logic ok);
        logic k1, k2, k3;
        start;
        xb({ADDR, 1'b0}, 1'b1, k1);
        xb(ra, 1'b1, k2);
        start;
        xb({ADDR, 1'b1}, 1'b1, k3);
        xb(8'hff, 1'b1, a);
        rd_data_o <= rx;
        rd_valid_o <= 1'b1;
        @(posedge clk_i);
        rd_valid_o <= 1'b0;
        stop;
        ok = k1 & k2 & k3;
    endtask
endmodule // apc_host

// *** testbench/tb.sv ***
`timescale 1ns/1ps
// ======================================================================
// self checking bench for the control port register slice
module tb;
    logic        clk, rst_n, h_scl, h_sda, sda_w, dsda, oe_n;
    logic        en, rec, ev, asi, rnd_on, rd_v;
    logic [3:0]  fix;
    logic [7:0]  rd_d, page, pg, sum, v;
    logic [1:0]  pol, chn, csrc, rate;
    logic        up, dn, cust, imode, run, pin;
    logic [7:0]  exp_q[$];
    integer      seed = 54325;
    int          n_errors = 0;
    int          n_checks = 0;

    // open drain wire: low if either side pulls
    assign sda_w = h_sda & (oe_n | dsda);

    apc_page_regs apc_page_regs_i (.clk_i(clk), .rst_n_i(rst_n),
        .scl_i(h_scl), .sda_i(sda_w), .sda_o(dsda), .sda_oe_n_o(oe_n),
        .activity_detect_enable_i(en), .recording_active_i(rec),
        .detector_event_i(ev), .asi_data_i(asi),
        .auto_power_policy_o(pol), .event_power_up_en_o(up),
        .event_power_down_en_o(dn), .monitored_channel_select_o(chn),
        .detector_clock_source_o(csrc), .use_custom_clock_o(cust),
        .external_clock_rate_select_o(rate),
        .serial_out_interrupt_mode_o(imode), .detector_run_o(run),
        .serial_data_output_pin_o(pin), .current_page_o(page));
    apc_host apc_host_i (.clk_i(clk), .sda_i(sda_w), .scl_o(h_scl),
        .sda_o(h_sda), .rd_valid_o(rd_v), .rd_data_o(rd_d));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // side inputs: random traffic, or held values while a case pins them
    always @(posedge clk) begin
        if (rnd_on)
            {en, rec, ev, asi} <= 4'($random(seed));
        else
            {en, rec, ev, asi} <= fix;
    end

    // read results come back in order, so the oldest note is the match
    always @(posedge clk) begin
        if (rd_v === 1'b1)
            chk(rd_d, exp_q.pop_front());
    end

    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_checks++;
        if (s !== e) begin
            n_errors++;
            $display("FAIL %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // checksum tracks every write; a write to it on page zero reloads it
    task automatic w(input logic [7:0] ra, input logic [7:0] d);
        logic ok;
        apc_host_i.wr(ra, d, ok);
        chk(8'(ok), 8'h01);
        if (pg == 8'h00 && ra == 8'h7e)
            sum = d;
        else
            sum = sum + d;
        if (ra == 8'h00)
            pg = d;
    endtask

    task automatic rd(input logic [7:0] ra, input logic [7:0] e);
        logic ok;
        exp_q.push_back(e);
        apc_host_i.rd(ra, ok);
        chk(8'(ok), 8'h01);
    endtask

    task automatic cfg_chk(input logic [7:0] d);
        chk(8'(pol), 8'(d[7:6]));
        chk(8'(up), 8'(d[7:6] == 2'h1 || d[7:6] == 2'h2));
        chk(8'(dn), 8'(d[7:6] == 2'h1 || d[7:6] == 2'h3));
        chk(8'(chn), 8'(d[5:4]));
        chk(8'(csrc), 8'(d[3:2]));
        chk(8'(cust), 8'(d[3:2] == 2'h3));
        chk(8'(rate), 8'(d[1:0]));
    endtask

    task automatic finish_test;
        if (n_errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // generous bound, the sequence needs roughly 21000 clocks
    initial begin
        tk(90000);
        n_errors++;
        finish_test;
    end

    // only listed page-1 offsets are ever written
    initial begin
        // side inputs have their own driver; only its controls start here
        {rst_n, rnd_on, fix} = 6'h00;
        pg = 8'h00;
        sum = 8'h00;
        tk(4);
        rst_n <= 1'b1;
        tk(4);
        chk(8'(chn), 8'h02);
        rd(8'h00, 8'h00);
        w(8'h00, 8'h01);
        chk(page, 8'h01);
        rd(8'h1e, 8'h20);
        rd(8'h1f, 8'h08);
        // every code of every field, then one random pattern
        for (int i = 0; i < 5; i++) begin
            v = (i < 4) ? {4{2'(i)}} : 8'($random(seed));
            w(8'h1e, v);
            rd(8'h1e, v);
            cfg_chk(v);
        end
        // held side values change on the edge, so the driver never races
        fix <= 4'b1110;
        w(8'h1f, 8'hff);
        rd(8'h1f, 8'hd8);
        chk(8'(run), 8'h01);
        chk(8'(imode), 8'h00);
        fix <= 4'b1010;
        tk(3);
        chk(8'(imode), 8'h01);
        chk(8'(pin), 8'h01);
        w(8'h1f, 8'h00);
        chk(8'(pin), 8'h00);
        fix <= 4'b1110;
        tk(3);
        chk(8'(run), 8'h00);
        fix <= 4'b0010;
        tk(3);
        chk(8'(run), 8'h00);
        w(8'h00, 8'h05);
        rd(8'h00, 8'h05);
        chk(page, 8'h05);
        w(8'h00, 8'hff);
        rd(8'h00, 8'hff);
        w(8'h00, 8'h00);
        rd(8'h7e, sum);
        w(8'h7e, 8'h5a);
        w(8'h00, 8'h03);
        w(8'h00, 8'h00);
        rd(8'h7e, sum);
        // interrupt pin mode and detection during recording stay on, so
        // the random phase exercises the pin and run gating assertions
        w(8'h00, 8'h01);
        rd(8'h20, 8'h00);
        w(8'h1f, 8'h48);
        rd(8'h1f, 8'h48);
        rnd_on <= 1'b1;
        tk(400);
        finish_test;
    end
endmodule // tb
